//--- pdl_consts.svh
// Constants for the pipeline delay line: sizes, offsets, fields, reset values
`ifndef PDL_CONSTS_SVH
`define PDL_CONSTS_SVH
// ==========================================
// Datapath format
`define PDL_INT_BITS 16
`define PDL_FRAC_BITS 0
`define PDL_STAGES 4
`define PDL_PH_MAX 8
`define PDL_PH_CW 3
// ==========================================
// Register byte offsets
`define PDL_OFS_CTRL 4'h0
`define PDL_OFS_MASK 4'h4
`define PDL_OFS_RSTV 4'h8
`define PDL_OFS_STAT 4'hc
// ==========================================
// Fields and reset values
`define PDL_CTRL_NZ 0
`define PDL_CTRL_LEN_LO 4
`define PDL_STAT_ACT 8
`define PDL_CTRL_RST 32'h0000_0000
`define PDL_CTRL_NZ_RST 1'b0
`define PDL_MASK_RST 8'h01
`define PDL_RSTV_RST 16'h0000
`define PDL_RESP_OK 2'h0
`define PDL_RESP_ERR 2'h2
`endif

//--- pdl_pkg.sv
// Types for the pipeline delay line
`include "pdl_consts.svh"
package pdl_pkg;
  localparam int W = `PDL_INT_BITS + `PDL_FRAC_BITS;
  typedef logic [W-1:0] pdl_word_t;
  typedef logic [`PDL_STAGES-1:0][W-1:0] pdl_pipe_t;
  typedef struct packed {
    pdl_pipe_t pipe;
    logic [`PDL_PH_CW-1:0] phase;
    logic nz_en;
    logic [`PDL_PH_CW-1:0] len_m1;
    logic [`PDL_PH_MAX-1:0] mask;
    pdl_word_t rstv;
    logic aw_ok;
    logic w_ok;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic sign;
  } pdl_state_t;
endpackage

//--- pdl_delay.sv
// Pipeline delay line with phase mask, clock enable, sync clear and AXI4-Lite control
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pdl_consts.svh"
module pdl_delay #(
  parameter bit USE_ENA = 1'b1,
  parameter bit USE_SCLR = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pdl_pkg::pdl_word_t din,
  input wire logic adv_en,
  input wire logic sync_clr,
  output logic [pdl_pkg::W-1:0] dout,
  output logic dout_sign,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pdl_pkg::*;

  // ==========================================
  // Static format checks
  localparam int STAGES = `PDL_STAGES;
  localparam int MSB = W - 1;
  if (STAGES < 1) begin : g_bad_stages
    $error("Stage count must be at least one");
  end
  // Word is integer plus fraction bits; zero fraction for integer formats
  localparam int FMT_W = `PDL_INT_BITS + `PDL_FRAC_BITS;
  if (FMT_W != W) begin : g_bad_width
    $error("Word width mismatch");
  end

  pdl_state_t st_r;
  pdl_state_t st_nxt;

  logic gate;
  logic clr;
  logic active;
  logic adv;
  pdl_word_t rst_const;
  logic [31:0] wr_merged;
  logic [31:0] cur_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  pdl_pipe_t shifted;

  // ==========================================
  // Datapath controls
  assign gate = USE_ENA ? adv_en : 1'b1;
  assign clr = USE_SCLR ? sync_clr : 1'b0;
  assign active = st_r.mask[st_r.phase];
  assign adv = gate & active;
  // Zero unless the non-zero option is on; costs a mux per stage bit
  assign rst_const = st_r.nz_en ? st_r.rstv : '0;

  // One shift per advance; stage 0 takes the input word
  assign shifted[0] = din;
  for (genvar i = 1; i < STAGES; i++) begin : g_shift
    assign shifted[i] = st_r.pipe[i-1];
  end

  // ==========================================
  // Register read mux
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PDL_OFS_CTRL: begin
        rd_word = '0;
        rd_word[`PDL_CTRL_NZ] = st_r.nz_en;
        rd_word[`PDL_CTRL_LEN_LO +: `PDL_PH_CW] = st_r.len_m1;
      end
      `PDL_OFS_MASK: rd_word = {24'h00_0000, st_r.mask};
      `PDL_OFS_RSTV: rd_word = {{(32-W){1'b0}}, st_r.rstv};
      `PDL_OFS_STAT: begin
        rd_word = '0;
        rd_word[`PDL_CTRL_LEN_LO-1:0] = {1'b0, st_r.phase};
        rd_word[`PDL_STAT_ACT] = active;
      end
      default: begin
        rd_word = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Current value of the addressed writable register, for byte merging
  always_comb begin
    wr_hit = 1'b1;
    case (st_r.awaddr)
      `PDL_OFS_CTRL: begin
        cur_word = '0;
        cur_word[`PDL_CTRL_NZ] = st_r.nz_en;
        cur_word[`PDL_CTRL_LEN_LO +: `PDL_PH_CW] = st_r.len_m1;
      end
      `PDL_OFS_MASK: cur_word = {24'h00_0000, st_r.mask};
      `PDL_OFS_RSTV: cur_word = {{(32-W){1'b0}}, st_r.rstv};
      default: begin
        cur_word = '0;
        wr_hit = 1'b0;
      end
    endcase
  end

  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wr_merged[8*b +: 8] = st_r.wstrb[b] ? st_r.wdata[8*b +: 8] : cur_word[8*b +: 8];
  end

  // ==========================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Pipeline: clear wins over the gate so a stalled line still flushes
    if (clr) begin
      st_nxt.pipe = {STAGES{rst_const}};
    end else if (adv) begin
      st_nxt.pipe = shifted;
    end
    // Phase walks only on gated cycles; a stall freezes the pattern too
    if (gate) begin
      if (st_r.phase >= st_r.len_m1) begin
        st_nxt.phase = '0;
      end else begin
        st_nxt.phase = st_r.phase + 1'b1;
      end
    end
    st_nxt.sign = st_nxt.pipe[STAGES-1][MSB];
    // Write address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? `PDL_RESP_OK : `PDL_RESP_ERR;
      case (st_r.awaddr)
        `PDL_OFS_CTRL: begin
          st_nxt.nz_en = wr_merged[`PDL_CTRL_NZ];
          st_nxt.len_m1 = wr_merged[`PDL_CTRL_LEN_LO +: `PDL_PH_CW];
          st_nxt.phase = '0;
        end
        `PDL_OFS_MASK: st_nxt.mask = wr_merged[`PDL_PH_MAX-1:0];
        `PDL_OFS_RSTV: st_nxt.rstv = wr_merged[W-1:0];
        default: st_nxt.bresp = `PDL_RESP_ERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_ok && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_ok && !st_nxt.bvalid;
    // Read: one outstanding, answer the cycle after the address is taken
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_hit ? `PDL_RESP_OK : `PDL_RESP_ERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.mask <= `PDL_MASK_RST;
      st_r.nz_en <= `PDL_CTRL_NZ_RST;
      st_r.rstv <= `PDL_RSTV_RST;
      st_r.pipe <= {STAGES{`PDL_RSTV_RST}};
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign dout = st_r.pipe[STAGES-1];
  assign dout_sign = st_r.sign;
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Depth 4 here matches the fixed stage count
  chk_full_delay: assert property (
    (adv && !clr)[*4] |=> dout == $past(din, 4))
    else $error("Output does not follow input by stage count");
  chk_gate_hold: assert property (
    (!gate && !clr) |=> $stable(st_r.pipe))
    else $error("Stages moved while gate low");
  chk_clear_load: assert property (
    clr |=> (dout == $past(rst_const)) && (st_r.pipe[0] == $past(rst_const)))
    else $error("Clear did not load reset constant");
  chk_mask_one: assert property (
    (st_r.mask[0] && st_r.len_m1 == '0 && gate && !clr) |=> st_r.pipe[0] == $past(din))
    else $error("Mask one missed a sample");
  chk_alt_phase: assert property (
    (st_r.len_m1 == 3'h1 && st_r.mask[1:0] == 2'b01 && gate && active && !st_nxt.bvalid)
      |=> !gate || !active)
    else $error("Pattern 10 did not alternate");
  chk_block_phase: assert property (
    (!active && !clr) |=> $stable(st_r.pipe))
    else $error("Blocked phase passed data");
  chk_nz_reset: assert property (
    (clr && st_r.nz_en) |=> st_r.pipe[STAGES-1] == $past(st_r.rstv))
    else $error("Non-zero reset value not loaded");
  chk_zero_reset: assert property (
    (clr && !st_r.nz_en) |=> st_r.pipe == '0)
    else $error("Zero reset not applied");
  chk_sign_bit: assert property (
    dout_sign == dout[MSB])
    else $error("Sign flag differs from word MSB");
  chk_bresp_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");

  cov_full_pass: cover property ((adv && !clr)[*4]);
  cov_clear_stall: cover property (clr && !gate);
  cov_blocked: cover property (gate && !active);
  cov_rd_wr: cover property (s_axi_bvalid && s_axi_rvalid);
endmodule

//--- pdl_src.sv
// Upstream word source for the delay line bench
`timescale 1ns/1ps
module pdl_src (
  input wire logic aclk,
  input wire logic aresetn,
  output pdl_pkg::pdl_word_t din
);
  import pdl_pkg::*;
  // ========
  // Source
  // Odd step crosses the sign bit often
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din <= '0;
    end else begin
      din <= din + 16'h1357;
    end
  end
endmodule

//--- pdl_delay_tb_top.sv
// Self-checking bench for the pipeline delay line
`timescale 1ns/1ps
`include "pdl_consts.svh"
module pdl_delay_tb_top;
  import pdl_pkg::*;
  logic aclk = 0, aresetn = 0, adv_en = 0, sync_clr = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, dout_sign;
  logic [1:0] bresp, rresp;
  pdl_word_t din, dout, m_rv;
  logic cmp_on = 0, m_nz = 0;
  logic [2:0] m_len = 0, ph = 0;
  logic [7:0] m_mask = 0;
  pdl_pipe_t ref_p = 0;
  int error_cnt = 0, check_count = 0;
  always #5 aclk = ~aclk;
  pdl_src src (.aclk(aclk), .aresetn(aresetn), .din(din));
  pdl_delay uut (.aclk(aclk), .aresetn(aresetn), .din(din), .adv_en(adv_en), .sync_clr(sync_clr),
    .dout(dout), .dout_sign(dout_sign), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ========
  // Reporting
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic timeout;
    error_cnt++;
    $display("MISMATCH bus answer expected valid seen none");
    give_verdict();
  endtask
  // ========
  // Bus master, valid held until its own ready
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ok;
    ok = 0;
    // Edge first, so a ready dropped by the last call never rises in the same step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        ok = 1;
        bready <= 1'h0;
      end
    end
    if (!ok) timeout();
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ok;
    ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        ok = 1;
        rready <= 1'h0;
      end
    end
    if (!ok) timeout();
  endtask
  // ========
  // Reference pipeline, only trusted once synced
  // Phase pinned to zero until compares start, as the CTRL write leaves it
  always @(posedge aclk) begin
    if (sync_clr) begin
      ref_p <= {`PDL_STAGES{m_nz ? m_rv : 16'h0}};
    end else if (adv_en && m_mask[ph]) begin
      ref_p <= {ref_p[`PDL_STAGES-2:0], din};
    end
    if (!cmp_on) begin
      ph <= 3'h0;
    end else if (adv_en) begin
      ph <= (ph == m_len) ? 3'h0 : ph + 3'h1;
    end
  end
  always @(negedge aclk) begin
    if (cmp_on) begin
      cmp("dout", ref_p[`PDL_STAGES-1], dout);
      cmp("sign", ref_p[`PDL_STAGES-1][W-1], dout_sign);
    end
  end
  // ========
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(`PDL_OFS_CTRL, d, r);
    cmp("ctrl rst", `PDL_CTRL_RST, d);
    axr(`PDL_OFS_MASK, d, r);
    cmp("mask rst", {24'h0, `PDL_MASK_RST}, d);
    axr(`PDL_OFS_RSTV, d, r);
    cmp("rstv rst", {16'h0, `PDL_RSTV_RST}, d);
    axw(`PDL_OFS_RSTV, 32'hffff_ffff, r);
    axr(`PDL_OFS_RSTV, d, r);
    cmp("rstv width", 32'h0000_ffff, d);
    axw(`PDL_OFS_STAT, 32'h1, r);
    cmp("stat bresp", `PDL_RESP_ERR, r);
    axr(`PDL_OFS_STAT, d, r);
    cmp("stat rresp", `PDL_RESP_OK, r);
    cmp("word width", 16, $bits(dout));
    cmp("idle dout", 16'h0, dout);
  endtask
  // Gate low while programming keeps the phase at zero
  task automatic run_pat(input logic [2:0] len, input logic [7:0] mk, input logic nz, input pdl_word_t rv);
    logic [1:0] r;
    adv_en <= 1'h0;
    cmp_on <= 1'h0;
    axw(`PDL_OFS_MASK, {24'h0, mk}, r);
    axw(`PDL_OFS_RSTV, {16'h0, rv}, r);
    axw(`PDL_OFS_CTRL, {25'h0, len, 3'h0, nz}, r);
    cmp("ctrl bresp", `PDL_RESP_OK, r);
    {m_len, m_mask, m_nz, m_rv} = {len, mk, nz, rv};
    sync_clr <= 1'h1;
    @(posedge aclk);
    sync_clr <= 1'h0;
    @(posedge aclk);
    cmp("cleared", nz ? rv : 16'h0, dout);
    cmp_on <= 1'h1;
    adv_en <= 1'h1;
    repeat (12) @(posedge aclk);
    adv_en <= 1'h0;
    repeat (3) @(posedge aclk);
    sync_clr <= 1'h1;
    @(posedge aclk);
    sync_clr <= 1'h0;
    adv_en <= 1'h1;
    repeat (16) @(posedge aclk);
    cmp_on <= 1'h0;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    run_pat(3'h0, 8'h01, 1'h0, 16'h0);
    run_pat(3'h1, 8'h01, 1'h1, 16'h8001);
    run_pat(3'h3, 8'h02, 1'h0, 16'h5555);
    run_pat(3'h7, 8'h81, 1'h1, 16'h7ffe);
    give_verdict();
  end
endmodule
